//--- clock_gate_pkg.sv
package clock_gate_pkg;

  localparam logic [11:0] run_clock_gate_0_off = 12'h100;
  localparam logic [11:0] sleep_clock_gate_0_off = 12'h110;
  localparam logic [11:0] deep_sleep_clock_gate_0_off = 12'h120;
  localparam logic [11:0] run_clock_config_off = 12'h060;
  localparam logic [11:0] gate_status_off = 12'h130;

  localparam int fieldbus_unit_gate_pos = 24;
  localparam int low_power_keeper_gate_pos = 6;
  localparam int watchdog_gate_pos = 3;
  localparam int auto_gating_select_pos = 0;
  localparam int status_mode_pos = 8;

  localparam logic [31:0] gate_reset_word = 32'h00000040;
  localparam logic [31:0] gate_writable_mask = 32'h01000048;
  localparam logic [31:0] config_reset_word = 32'h00000000;

  typedef enum logic [1:0]
  {
    mode_run = 2'b00,
    mode_sleep = 2'b01,
    mode_deep_sleep = 2'b10
  } power_mode_e;

  typedef struct packed
  {
    logic fieldbus;
    logic keeper;
    logic watchdog;
  } unit_en_s;

endpackage : clock_gate_pkg

//--- low_power_clock_gating_0.sv
`timescale 1ns/10ps
`default_nettype none
module low_power_clock_gating_0
  import clock_gate_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic [2:0] unit_access,
  output logic [2:0] unit_fault,
  output logic [2:0] unit_en,
  output logic [2:0] unit_clk
);

  logic [31:0] run_gate_q;
  logic [31:0] sleep_gate_q;
  logic [31:0] deep_gate_q;
  logic auto_gate_q;
  power_mode_e mode_q;
  power_mode_e mode_d;
  unit_en_s en_q;
  unit_en_s en_d;
  logic [31:0] prdata_q;
  logic err_q;
  logic setup;
  logic access;
  logic [2:0] latch_en;
  logic [31:0] rd_word;
  logic rd_err;

  function automatic unit_en_s fields_of(input logic [31:0] word);
    unit_en_s u;
    u.fieldbus = word[fieldbus_unit_gate_pos];
    u.keeper = word[low_power_keeper_gate_pos];
    u.watchdog = word[watchdog_gate_pos];
    return u;
  endfunction : fields_of

  function automatic logic [31:0] word_of(input unit_en_s u);
    logic [31:0] w;
    w = 32'h00000000;
    w[fieldbus_unit_gate_pos] = u.fieldbus;
    w[low_power_keeper_gate_pos] = u.keeper;
    w[watchdog_gate_pos] = u.watchdog;
    return w;
  endfunction : word_of

  assign setup = psel & ~penable;
  assign access = psel & penable & ce;

  // mode decode; deep sleep outranks sleep
  always_comb
  begin
    if (deep_sleep_req)
    begin
      mode_d = mode_deep_sleep;
    end
    else if (sleep_req)
    begin
      mode_d = mode_sleep;
    end
    else
    begin
      mode_d = mode_run;
    end
  end

  // effective enables picked by mode when auto gating is selected, else run register
  always_comb
  begin
    case (mode_q)
      mode_sleep: en_d = auto_gate_q ? fields_of(sleep_gate_q) : fields_of(run_gate_q);
      mode_deep_sleep: en_d = auto_gate_q ? fields_of(deep_gate_q) : fields_of(run_gate_q);
      mode_run: en_d = fields_of(run_gate_q);
      default: en_d = fields_of(run_gate_q);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= mode_run;
    end
    else if (ce)
    begin
      mode_q <= mode_d;
    end
  end

  // enables switch only on a clock edge, so gated clocks see a clean change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= fields_of(gate_reset_word);
    end
    else if (ce)
    begin
      en_q <= en_d;
    end
  end

  // register writes; only documented enable bits are stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_gate_q <= gate_reset_word;
      sleep_gate_q <= gate_reset_word;
      deep_gate_q <= gate_reset_word;
      auto_gate_q <= config_reset_word[auto_gating_select_pos];
    end
    else if (access && pwrite && !err_q)
    begin
      case (paddr)
        run_clock_gate_0_off: run_gate_q <= pwdata & gate_writable_mask;
        sleep_clock_gate_0_off: sleep_gate_q <= pwdata & gate_writable_mask;
        deep_sleep_clock_gate_0_off: deep_gate_q <= pwdata & gate_writable_mask;
        run_clock_config_off: auto_gate_q <= pwdata[auto_gating_select_pos];
        default: auto_gate_q <= auto_gate_q;
      endcase
    end
  end

  // read mux; status is read-only, writes to it fault
  always_comb
  begin
    rd_err = 1'b0;
    case (paddr)
      run_clock_gate_0_off: rd_word = run_gate_q;
      sleep_clock_gate_0_off: rd_word = sleep_gate_q;
      deep_sleep_clock_gate_0_off: rd_word = deep_gate_q;
      run_clock_config_off: rd_word = {31'h00000000, auto_gate_q};
      gate_status_off:
      begin
        rd_word = word_of(en_q);
        rd_word[status_mode_pos +: 2] = mode_q;
        rd_err = pwrite;
      end
      default:
      begin
        rd_word = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  // read data captured in the setup cycle so prdata comes from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end
    else if (ce && setup)
    begin
      prdata_q <= pwrite ? 32'h00000000 : rd_word;
      err_q <= rd_err;
    end
  end

  assign pready = access;
  assign prdata = prdata_q;
  assign pslverr = access & err_q;

  // latch open while pclk low keeps gated clocks free of runts
  always_latch
  begin
    if (!pclk)
    begin
      latch_en = en_q;
    end
  end

  assign unit_en = en_q;
  assign unit_clk = {3{pclk}} & latch_en;
  assign unit_fault = unit_access & ~en_q;

endmodule : low_power_clock_gating_0
`default_nettype wire

//--- gate_chk.sv
`timescale 1ns/10ps
`default_nettype none
module gate_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic [2:0] unit_access,
  input wire logic [2:0] unit_fault,
  input wire logic [2:0] unit_en,
  input wire logic [2:0] unit_clk
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // no write, steady mode requests and steady ce; a ce pulse delays the mode update
  sequence calm;
    !(psel && pwrite) && $stable(sleep_req) && $stable(deep_sleep_req) && $stable(ce);
  endsequence
  a_fault_gated: assert property (unit_fault == (unit_access & ~unit_en))
    else $error("fault mismatch");
  a_clk_follows: assert property (@(negedge pclk) unit_en == $past(unit_en) |-> unit_clk == unit_en)
    else $error("gated clock mismatch");
  a_reset_en: assert property ($rose(presetn) |-> unit_en == 3'b010)
    else $error("reset enables wrong");
  a_calm_steady: assert property (calm [*3] |-> $stable(unit_en))
    else $error("enables moved");
  a_ce_freeze: assert property (!ce |=> $stable(unit_en))
    else $error("state moved with ce low");
  a_ready_zero: assert property (pready == (psel && penable && ce))
    else $error("ready wrong");
  a_err_access: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_fault_idle: assert property (unit_access == 3'h0 |-> unit_fault == 3'h0)
    else $error("spurious fault");
endmodule : gate_chk
bind low_power_clock_gating_0 gate_chk i_chk (.*);
`default_nettype wire

//--- low_power_clock_gating_0_bench.sv
`timescale 1ns/10ps
`default_nettype none
module low_power_clock_gating_0_bench import clock_gate_pkg::*;;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic sleep_req = 0, deep_sleep_req = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [2:0] unit_access = 3'h0, unit_fault, unit_en, unit_clk, x;
  logic [31:0] m[4];
  logic [11:0] ad[4] = '{run_clock_gate_0_off, sleep_clock_gate_0_off,
    deep_sleep_clock_gate_0_off, run_clock_config_off};
  int errors = 0, comparisons = 0, seed = 32'h128B, r, md;
  low_power_clock_gating_0 i_dut (.*);
  always #12.5 pclk = ~pclk;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      errors++;
    end
  endtask : chk
  // no wait count assumed; the watchdog ends a hang
  task automatic apb(logic w, logic [11:0] a, logic [31:0] v);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic rdall;
    for (int k = 0; k < 4; k++)
    begin
      apb(0, ad[k], 0);
      chk("register", rd, m[k]);
    end
  endtask : rdall
  task complete_run;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  function automatic logic [2:0] en(logic [31:0] v);
    return {v[24], v[6], v[3]};
  endfunction : en
  initial
  begin
    #100us;
    errors++;
    complete_run;
  end
  initial
  begin
    m = '{gate_reset_word, gate_reset_word, gate_reset_word, config_reset_word};
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdall;
    apb(0, 12'h0FC, 0);
    chk("unmapped", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1, gate_status_off, 32'hFFFFFFFF);
    chk("status write", {31'h0, er}, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      // random words also poke the reserved bits
      for (int k = 0; k < 4; k++)
      begin
        d = (k == 3) ? i : $random(seed);
        apb(1, ad[k], d);
        m[k] = d & ((k == 3) ? 32'h1 : gate_writable_mask);
      end
      rdall;
      for (int j = 0; j < 4; j++)
      begin
        ce <= 0;
        sleep_req <= j[0];
        deep_sleep_req <= j[1];
        @(posedge pclk);
        ce <= 1;
        repeat (3) @(posedge pclk);
        md = j[1] ? 2 : j;
        r = md;
        if (!m[3][0])
          r = 0;
        x = en(m[r]);
        chk("enables", unit_en, x);
        unit_access <= 3'($random(seed));
        @(posedge pclk);
        chk("fault", unit_fault, unit_access & ~x);
        apb(0, gate_status_off, 0);
        chk("status", rd, m[r] | (md << status_mode_pos));
      end
    end
    complete_run;
  end
endmodule : low_power_clock_gating_0_bench
`default_nettype wire
